/* dv/imdd_xmem.sv */
// external data space and signature array model behind the decoder
`timescale 1ns/1ps
module imdd_xmem (
  input  wire logic                ref_clk,
  input  wire imdd_pkg::imdd_ext_s ext_req,
  output logic                     last_sig,
  output logic [15:0]              last_addr
);
  logic [7:0] xmem [0:255];
  logic [7:0] sig_mem [0:511];

  // store writes by space; only external moves ever reach here
  always_ff @(posedge ref_clk) begin
    if (ext_req.valid) begin
      last_sig  <= ext_req.sig;
      last_addr <= ext_req.addr;
      if (ext_req.write && ext_req.sig)
        sig_mem[ext_req.addr[8:0]] <= ext_req.wdata;
      else if (ext_req.write)
        xmem[ext_req.addr[7:0]] <= ext_req.wdata; // low byte only, small model
    end
  end
endmodule

/* dv/tb_imdd_decoder.sv */
// self-checking bench for the internal data memory decoder
`timescale 1ns/1ps
module tb_imdd_decoder;
  logic                ref_clk;
  logic                rst_n;
  imdd_pkg::imdd_req_s req;
  logic                wr_stb;
  logic                rd_stb;
  logic [7:0]          rd_data;
  imdd_pkg::imdd_ext_s ext_req;
  logic [1:0]          bank_select;
  logic                last_sig;
  logic [15:0]         last_addr;
  int                  mismatches;
  int                  n_tests;

  imdd_decoder imdd_decoder_i (
    .ref_clk     (ref_clk),
    .rst_n       (rst_n),
    .req         (req),
    .wr_stb      (wr_stb),
    .rd_stb      (rd_stb),
    .rd_data     (rd_data),
    .ext_req     (ext_req),
    .bank_select (bank_select)
  );

  imdd_xmem imdd_xmem_i (
    .ref_clk   (ref_clk),
    .ext_req   (ext_req),
    .last_sig  (last_sig),
    .last_addr (last_addr)
  );

  // 100 ns period
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one strobe cycle, then settle to the answer cycle
  task automatic acc(input imdd_pkg::imdd_kind_e k, input logic [15:0] a,
                     input logic [7:0] d, input logic wr);
    @(posedge ref_clk);
    req    <= '{kind: k, addr: a, wdata: d};
    wr_stb <= wr;
    rd_stb <= !wr;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
    rd_stb <= 1'b0;
    @(negedge ref_clk);
  endtask

  task automatic rd(input imdd_pkg::imdd_kind_e k, input logic [15:0] a,
                    input logic [7:0] exp);
    acc(k, a, 8'h00, 1'b0);
    chk("rd_data", {8'h00, rd_data}, {8'h00, exp});
  endtask

  // write an external byte and look at the forwarded request
  task automatic xw(input logic [15:0] a, input logic sig);
    acc(imdd_pkg::acc_external, a, 8'h3c, 1'b1);
    chk("ext valid", {15'h0000, ext_req.valid}, 16'h0001);
    chk("ext addr", ext_req.addr, a);
    chk("ext sig", {15'h0000, ext_req.sig}, {15'h0000, sig});
    chk("ext write", {15'h0000, ext_req.write}, 16'h0001);
    chk("ext wdata", {8'h00, ext_req.wdata}, 16'h003c);
    @(negedge ref_clk);
    chk("xmem sig", {15'h0000, last_sig}, {15'h0000, sig});
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    rst_n  = 1'b0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    req    = '0;
    mismatches = 0;
    n_tests    = 0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(negedge ref_clk);
    chk("bank", {14'h0000, bank_select}, 16'h0000);
    chk("ext idle", {15'h0000, ext_req.valid}, 16'h0000);
    // plain ram, no setup needed
    acc(imdd_pkg::acc_direct, 16'h0045, 8'ha5, 1'b1);
    rd(imdd_pkg::acc_direct, 16'h0045, 8'ha5);
    acc(imdd_pkg::acc_direct, 16'h0001, 8'h45, 1'b1);
    rd(imdd_pkg::acc_indirect, 16'h0001, 8'ha5);
    // each bank writes its own register five
    for (int b = 0; b < 4; b++) begin
      acc(imdd_pkg::acc_direct, 16'h00d0, {3'h0, b[1:0], 3'h0}, 1'b1);
      chk("bank", {14'h0000, bank_select}, {14'h0000, b[1:0]});
      acc(imdd_pkg::acc_register, 16'h0005, 8'h50 + b[7:0], 1'b1);
    end
    for (int b = 0; b < 4; b++) begin
      rd(imdd_pkg::acc_direct, {11'h000, b[1:0], 3'h5}, 8'h50 + b[7:0]);
    end
    rd(imdd_pkg::acc_register, 16'h0005, 8'h53);
    // bit 13 lands in byte 22 bit 3
    acc(imdd_pkg::acc_bit, 16'h0013, 8'h01, 1'b1);
    rd(imdd_pkg::acc_direct, 16'h0022, 8'h08);
    rd(imdd_pkg::acc_bit, 16'h0013, 8'h01);
    // bit 3 of the status word cleared through the register bit space
    acc(imdd_pkg::acc_bit, 16'h00d3, 8'h00, 1'b1);
    chk("bank", {14'h0000, bank_select}, 16'h0002);
    // upper half: indirect reaches ram, direct reaches registers
    acc(imdd_pkg::acc_direct, 16'h00d0, 8'h00, 1'b1);
    acc(imdd_pkg::acc_direct, 16'h0000, 8'hd0, 1'b1);
    acc(imdd_pkg::acc_indirect, 16'h0000, 8'h5a, 1'b1);
    rd(imdd_pkg::acc_direct, 16'h00d0, 8'h00);
    rd(imdd_pkg::acc_indirect, 16'h0000, 8'h5a);
    acc(imdd_pkg::acc_stack, 16'h00f0, 8'hc3, 1'b1);
    rd(imdd_pkg::acc_stack, 16'h00f0, 8'hc3);
    acc(imdd_pkg::acc_direct, 16'h0085, 8'hff, 1'b1);
    rd(imdd_pkg::acc_direct, 16'h0085, 8'h00);
    // external moves with and without the signature window
    xw(16'h0100, 1'b0);
    rd(imdd_pkg::acc_external, 16'h0100, 8'h00);
    acc(imdd_pkg::acc_direct, 16'h0096, 8'h80, 1'b1);
    xw(16'h0100, 1'b0);
    acc(imdd_pkg::acc_direct, 16'h00a2, 8'h08, 1'b1);
    xw(16'h0100, 1'b1);
    xw(16'h0300, 1'b0);
    tally_and_finish();
  end
endmodule

/* hdl/imdd_decoder.sv */
// internal data memory decoder with 256-byte ram and its control registers
`timescale 1ns/1ps
`include "imdd_cfg.svh"

module imdd_decoder #(
  parameter int RAM_BYTES = `IMDD_RAM_BYTES
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire imdd_pkg::imdd_req_s req,
  input  wire logic              wr_stb,
  input  wire logic              rd_stb,
  output logic [7:0]             rd_data,
  output imdd_pkg::imdd_ext_s    ext_req,
  output logic [1:0]             bank_select
);

  logic [7:0]  ram [RAM_BYTES];
  logic [7:0]  psw_r;
  logic        pmwe_r;
  logic        signature_space_enable_r;
  logic [7:0]  rd_data_r;
  imdd_pkg::imdd_ext_s ext_r;

  logic [1:0]  bank;
  logic [7:0]  ptr_idx;
  logic [7:0]  ptr;
  logic [7:0]  ram_a;
  logic        ram_hit;
  logic [7:0]  sfr_a;
  logic        sfr_hit;
  logic        is_bit;
  logic [7:0]  byte_val;
  logic [7:0]  wbyte;
  logic [7:0]  rval;
  logic        ext_hit;
  logic        sig_hit;

  // register address within a bank
  function automatic logic [7:0] reg_idx(input logic [1:0] bs,
                                         input logic [2:0] rn);
    reg_idx = {3'b000, bs, rn};
  endfunction

  // byte that holds a bit address, in ram or in the register space
  function automatic logic [7:0] bit_byte(input logic [7:0] ba);
    if (!ba[7]) begin
      bit_byte = `IMDD_BIT_BASE + {4'h0, ba[6:3]};
    end else begin
      bit_byte = {ba[7:3], 3'b000};
    end
  endfunction

  // read of the peripheral register space; empty slots read zero
  function automatic logic [7:0] sfr_read(input logic [7:0] a,
                                          input logic [7:0] processor_status_word,
                                          input logic       pmwe,
                                          input logic       signature_space_enable);
    logic [7:0] v;
    v = 8'h00;
    if (a == `IMDD_PSW_ADDR) begin
      v = processor_status_word;
    end else if (a == `IMDD_MEMCTL_ADDR) begin
      v[`IMDD_PMWE_BIT] = pmwe;
    end else if (a == `IMDD_AUX_ADDR) begin
      v[`IMDD_SIGNATURE_SPACE_ENABLE_BIT] = signature_space_enable;
    end
    sfr_read = v;
  endfunction

  assign bank = {psw_r[`IMDD_PSW_BS_HI], psw_r[`IMDD_PSW_BS_LO]};

  // address decode; ram needs no enable, the access kind and, for direct and bit kinds, address bit 7 steer it
  always_comb begin
    ptr_idx = reg_idx(bank, {2'b00, req.addr[0]});
    ptr     = ram[ptr_idx];
    ram_a   = 8'h00;
    ram_hit = 1'b0;
    sfr_a   = 8'h00;
    sfr_hit = 1'b0;
    is_bit  = 1'b0;
    ext_hit = 1'b0;
    case (req.kind)
      imdd_pkg::acc_direct: begin
        if (req.addr[7]) begin
          sfr_hit = 1'b1;
          sfr_a   = req.addr[7:0];
        end else begin
          ram_hit = 1'b1;
          ram_a   = req.addr[7:0];
        end
      end
      imdd_pkg::acc_indirect: begin
        ram_hit = 1'b1;
        ram_a   = ptr;
      end
      imdd_pkg::acc_register: begin
        ram_hit = 1'b1;
        ram_a   = reg_idx(bank, req.addr[2:0]);
      end
      imdd_pkg::acc_bit: begin
        is_bit = 1'b1;
        if (req.addr[7]) begin
          sfr_hit = 1'b1;
          sfr_a   = bit_byte(req.addr[7:0]);
        end else begin
          ram_hit = 1'b1;
          ram_a   = bit_byte(req.addr[7:0]);
        end
      end
      imdd_pkg::acc_stack: begin
        ram_hit = 1'b1;
        ram_a   = req.addr[7:0];
      end
      imdd_pkg::acc_external: begin
        ext_hit = 1'b1;
      end
      default: begin
        ram_hit = 1'b0;
      end
    endcase
  end

  // signature only inside its window, everything above falls through
  assign sig_hit = pmwe_r && signature_space_enable_r &&
                   (req.addr < `IMDD_SIG_LIMIT);

  // byte seen by the access and the byte a write leaves behind
  always_comb begin
    if (ram_hit) begin
      byte_val = ram[ram_a];
    end else begin
      byte_val = sfr_read(sfr_a, psw_r, pmwe_r, signature_space_enable_r);
    end
    wbyte = req.wdata;
    rval  = byte_val;
    if (is_bit) begin
      wbyte = byte_val;
      wbyte[req.addr[2:0]] = req.wdata[0];
      rval  = {7'h00, byte_val[req.addr[2:0]]};
    end
    if (!(ram_hit || sfr_hit)) begin
      rval = 8'h00;
    end
  end

  // ram array; bit writes are read-modify-write of the containing byte
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < RAM_BYTES; i++) begin
        ram[i] <= 8'h00;
      end
    end else if (wr_stb && ram_hit) begin
      ram[ram_a] <= wbyte;
    end
  end

  // status word; the bank select bits live here
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      psw_r <= `IMDD_PSW_RST;
    end else if (wr_stb && sfr_hit && sfr_a == `IMDD_PSW_ADDR) begin
      psw_r <= wbyte;
    end
  end

  // memory control bits; other register slots simply drop writes
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pmwe_r  <= 1'b0;
      signature_space_enable_r <= 1'b0;
    end else if (wr_stb && sfr_hit) begin
      if (sfr_a == `IMDD_MEMCTL_ADDR) begin
        pmwe_r <= wbyte[`IMDD_PMWE_BIT];
      end
      if (sfr_a == `IMDD_AUX_ADDR) begin
        signature_space_enable_r <= wbyte[`IMDD_SIGNATURE_SPACE_ENABLE_BIT];
      end
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rd_data_r <= 8'h00;
    end else if (rd_stb) begin
      rd_data_r <= rval;
    end else begin
      rd_data_r <= 8'h00;
    end
  end

  // external moves leave as a registered one-cycle request
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ext_r <= '0;
    end else begin
      ext_r.valid <= ext_hit && (wr_stb || rd_stb);
      ext_r.write <= ext_hit && wr_stb;
      ext_r.sig   <= ext_hit && sig_hit;
      ext_r.addr  <= ext_hit ? req.addr : 16'h0000;
      ext_r.wdata <= (ext_hit && wr_stb) ? req.wdata : 8'h00;
    end
  end

  assign rd_data     = rd_data_r;
  assign ext_req     = ext_r;
  assign bank_select = bank;

  // checks on the decode
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  logic [7:0] reg_pos;
  assign reg_pos = {3'b000, bank, req.addr[2:0]};

  a_direct_low_ram: assert property (
    wr_stb && req.kind == imdd_pkg::acc_direct && !req.addr[7]
    |=> ram[$past(req.addr[7:0])] == $past(req.wdata))
    else $error("direct low write missed ram");

  a_bank_reg_map: assert property (
    wr_stb && req.kind == imdd_pkg::acc_register
    |=> ram[$past(reg_pos)] == $past(req.wdata))
    else $error("register write hit wrong bank byte");

  a_bank_from_psw: assert property (
    wr_stb && req.kind == imdd_pkg::acc_direct &&
    req.addr[7:0] == `IMDD_PSW_ADDR
    |=> bank_select == $past(req.wdata[4:3]))
    else $error("bank select not taken from status word");

  a_bit_alias: assert property (
    wr_stb && req.kind == imdd_pkg::acc_bit && !req.addr[7]
    |=> ram[`IMDD_BIT_BASE + {4'h0, $past(req.addr[6:3])}]
           [$past(req.addr[2:0])] == $past(req.wdata[0]))
    else $error("bit write not seen in byte");

  a_indirect_read: assert property (
    rd_stb && req.kind == imdd_pkg::acc_indirect
    |=> rd_data == $past(ram[ptr]))
    else $error("indirect read wrong byte");

  a_stack_upper: assert property (
    wr_stb && req.kind == imdd_pkg::acc_stack
    |=> ram[$past(req.addr[7:0])] == $past(req.wdata))
    else $error("stack write missed ram");

  a_indirect_not_sfr: assert property (
    wr_stb && req.kind == imdd_pkg::acc_indirect
    |=> $stable(psw_r) && $stable(pmwe_r) && $stable(signature_space_enable_r))
    else $error("indirect write reached a register");

  a_unmapped_zero: assert property (
    rd_stb && req.kind == imdd_pkg::acc_direct && req.addr[7] &&
    req.addr[7:0] != `IMDD_PSW_ADDR &&
    req.addr[7:0] != `IMDD_MEMCTL_ADDR &&
    req.addr[7:0] != `IMDD_AUX_ADDR
    |=> rd_data == 8'h00)
    else $error("empty register slot read nonzero");

  a_ext_route: assert property (
    (wr_stb || rd_stb) && req.kind == imdd_pkg::acc_external
    |=> ext_req.valid && ext_req.addr == $past(req.addr) &&
        ext_req.sig == $past(pmwe_r && signature_space_enable_r &&
                             req.addr < `IMDD_SIG_LIMIT))
    else $error("external move misrouted");

  a_ext_only_move: assert property (
    ext_req.valid |-> $past(req.kind == imdd_pkg::acc_external &&
                            (wr_stb || rd_stb)))
    else $error("external request without external move");

  c_bank_switch: cover property (
    wr_stb && req.kind == imdd_pkg::acc_direct &&
    req.addr[7:0] == `IMDD_PSW_ADDR ##1
    wr_stb && req.kind == imdd_pkg::acc_register);

  c_upper_indirect: cover property (
    rd_stb && req.kind == imdd_pkg::acc_indirect && ptr[7]);

  c_signature: cover property (ext_req.valid && ext_req.sig);

endmodule

/* shared/imdd_cfg.svh */
// address map, field positions and reset values of the data memory decoder
`ifndef IMDD_CFG_SVH
`define IMDD_CFG_SVH
`define IMDD_RAM_BYTES   256
`define IMDD_REG_BANKS   4
`define IMDD_BANK_REGS   8
`define IMDD_BIT_BASE    8'h20
`define IMDD_PSW_ADDR    8'hd0
`define IMDD_PSW_BS_LO   3
`define IMDD_PSW_BS_HI   4
`define IMDD_PSW_RST     8'h00
`define IMDD_MEMCTL_ADDR 8'h96
`define IMDD_PMWE_BIT    7
`define IMDD_AUX_ADDR    8'ha2
`define IMDD_SIGNATURE_SPACE_ENABLE_BIT   3
`define IMDD_SIG_LIMIT   16'h0200
`endif

/* shared/imdd_pkg.sv */
// access kinds and carrier structs of the data memory decoder
package imdd_pkg;
  typedef enum logic [2:0] {
    acc_direct,
    acc_indirect,
    acc_register,
    acc_bit,
    acc_stack,
    acc_external
  } imdd_kind_e;

  // one core access: kind, address (16 bits for external) and write byte
  typedef struct packed {
    imdd_kind_e  kind;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } imdd_req_s;

  // access forwarded to the external data space or signature array
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        sig;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } imdd_ext_s;
endpackage
